/* stop_mode_pkg.sv */
// package of register map, field positions and enums for the stop-mode controller
package stop_mode_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h008;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h00C;
  localparam logic [11:0] DOMAIN_ADDR = 12'h010;
  // control register bits
  localparam int CTRL_STOP_INSTR_EN = 0;
  localparam int CTRL_DEEP_STOP_SEL = 1;
  localparam int CTRL_LV_DETECT_EN = 2;
  localparam int CTRL_LV_STOP_EN = 3;
  localparam int CTRL_IREF_EN = 4;
  localparam int CTRL_IREF_STOP_EN = 5;
  localparam int CTRL_OSC_HIGH_RANGE = 6;
  localparam int CTRL_ADC_ASYNC_CLK = 7;
  localparam int CTRL_CMP_BANDGAP = 8;
  localparam int CTRL_RTC_STOP_EN = 9;
  localparam int CTRL_PD_ACK = 10;
  localparam int CTRL_W = 11;
  localparam logic [10:0] CTRL_RESET = 11'h001;
  // status / irq bits
  localparam int EV_STOP3 = 0;
  localparam int EV_STOP2 = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_ILLEGAL = 3;
  localparam int EV_W = 4;
  // domain state codes, two bits per domain
  localparam logic [1:0] DOM_ON = 2'h0;
  localparam logic [1:0] DOM_STANDBY = 2'h1;
  localparam logic [1:0] DOM_OFF = 2'h2;
  localparam int DOM_N = 13;
  // domain indices
  localparam int D_CPU = 0;
  localparam int D_RAM = 1;
  localparam int D_FLASH = 2;
  localparam int D_PORTS = 3;
  localparam int D_ADC = 4;
  localparam int D_CMP = 5;
  localparam int D_DEBUG = 6;
  localparam int D_CLKGEN = 7;
  localparam int D_SERIAL = 8;
  localparam int D_VDET = 9;
  localparam int D_TIMERS = 10;
  localparam int D_RTC = 11;
  localparam int D_CRYSTAL = 12;
  localparam int D_REG = 13;
  localparam int DOM_TOTAL = 14;
  typedef enum logic [1:0] {RUN, STOP3, STOP2} mode_t;
endpackage

/* stop_cfg_if.sv */
// interface carrying latched stop-entry configuration to the domain planner
`timescale 1ns/1ps
interface stop_cfg_if;
  logic debugOn;
  logic vdetOn;
  logic vdetStop;
  logic irefEn;
  logic irefStopEn;
  logic oscHigh;
  logic adcAsync;
  logic cmpBandgap;
  logic rtcEn;
  stop_mode_pkg::mode_t mode;
  modport src (output debugOn, vdetOn, vdetStop, irefEn, irefStopEn, oscHigh, adcAsync,
    cmpBandgap, rtcEn, mode);
  modport dst (input debugOn, vdetOn, vdetStop, irefEn, irefStopEn, oscHigh, adcAsync,
    cmpBandgap, rtcEn, mode);
endinterface

/* pin_sync.sv */
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      syncOut <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule

/* domain_plan.sv */
// combinational map from stop mode and latched config to per-domain power state
`timescale 1ns/1ps
module domain_plan (
  stop_cfg_if.dst cfg,
  output logic [2*stop_mode_pkg::DOM_TOTAL-1:0] domState
);
  logic vdetActive;
  always_comb begin
    vdetActive = cfg.vdetOn && cfg.vdetStop;
    domState = '0;
    for (int i = 0; i < stop_mode_pkg::DOM_TOTAL; i++) begin
      unique case (cfg.mode)
        stop_mode_pkg::STOP2: domState[2*i +: 2] = stop_mode_pkg::DOM_OFF;
        stop_mode_pkg::STOP3: domState[2*i +: 2] = stop_mode_pkg::DOM_STANDBY;
        default: domState[2*i +: 2] = stop_mode_pkg::DOM_ON;
      endcase
    end
    if (cfg.mode == stop_mode_pkg::STOP2) begin
      domState[2*stop_mode_pkg::D_RAM +: 2] = stop_mode_pkg::DOM_STANDBY;
      domState[2*stop_mode_pkg::D_REG +: 2] = stop_mode_pkg::DOM_STANDBY;
      domState[2*stop_mode_pkg::D_RTC +: 2] =
        cfg.rtcEn ? stop_mode_pkg::DOM_ON : stop_mode_pkg::DOM_OFF;
    end
    if (cfg.mode == stop_mode_pkg::STOP3) begin
      if (cfg.adcAsync && vdetActive)
        domState[2*stop_mode_pkg::D_ADC +: 2] = stop_mode_pkg::DOM_ON;
      if (!cfg.cmpBandgap || vdetActive)
        domState[2*stop_mode_pkg::D_CMP +: 2] = stop_mode_pkg::DOM_ON;
      if (cfg.debugOn)
        domState[2*stop_mode_pkg::D_DEBUG +: 2] = stop_mode_pkg::DOM_ON;
      if (cfg.irefEn && cfg.irefStopEn)
        domState[2*stop_mode_pkg::D_CLKGEN +: 2] = stop_mode_pkg::DOM_ON;
      if (vdetActive)
        domState[2*stop_mode_pkg::D_VDET +: 2] = stop_mode_pkg::DOM_ON;
      if (cfg.rtcEn)
        domState[2*stop_mode_pkg::D_RTC +: 2] = stop_mode_pkg::DOM_ON;
      if (cfg.debugOn || vdetActive)
        domState[2*stop_mode_pkg::D_REG +: 2] = stop_mode_pkg::DOM_ON;
      if (!cfg.oscHigh || vdetActive)
        domState[2*stop_mode_pkg::D_CRYSTAL +: 2] = stop_mode_pkg::DOM_ON;
    end
  end
endmodule

/* stop_mode_domain_control.sv */
// stop-mode controller: APB registers, mode selection, clock gating and domain states
// Overview of operation
// - stop gates all peripheral clocks
// - debug enable keeps only debug clock
// - debug enable promotes stop2 to stop3
// - low-voltage stop enable with detector enable promotes stop2
// - regulator on if debug or detector
// - converter on needs async clock, detector
// - bandgap comparator needs detector in stop3
// - clock source runs in stop3 if both enables
// - high-range oscillator needs detector
// - stop2 powers off nearly everything
// - stop3 holds logic in standby
// - stop disabled gives illegal-opcode reset
// - wake flag, pins latched after stop2 until acknowledge
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module stop_mode_domain_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stop_mode_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stopInstr,
  input wire logic debug_entry_enable,
  input wire logic wakeReq,
  input wire logic rtcWakeReq,
  output logic periphClkEn,
  output logic debugClkEn,
  output logic cpuClkEn,
  output logic illegalOpReset,
  output logic pinLatchHold,
  output logic [2*stop_mode_pkg::DOM_TOTAL-1:0] domainState,
  output logic irq
);
  logic [stop_mode_pkg::CTRL_W-1:0] ctrl_reg;
  logic [stop_mode_pkg::EV_W-1:0] evStat_reg;
  logic [stop_mode_pkg::EV_W-1:0] evMask_reg;
  logic [stop_mode_pkg::EV_W-1:0] evSet;
  logic powerdown_wake_flag_reg;
  logic cfgDebug_reg;
  logic cfgVdetOn_reg;
  logic cfgVdetStop_reg;
  logic cfgIref_reg;
  logic cfgIrefStop_reg;
  logic cfgOscHigh_reg;
  logic cfgAdcAsync_reg;
  logic cfgCmpBg_reg;
  logic cfgRtc_reg;
  stop_mode_pkg::mode_t mode_reg;
  stop_mode_pkg::mode_t mode_next;
  logic [1:0] wakeSync;
  logic wakeS;
  logic rtcWakeS;
  logic debugS;
  logic debugSync;
  logic apbWrite;
  logic apbRead;
  logic [2*stop_mode_pkg::DOM_TOTAL-1:0] planState;
  logic stopTake;
  logic stopEntry;

  stop_cfg_if cfgBus ();

  pin_sync #(.W(3)) uSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn({debug_entry_enable, rtcWakeReq, wakeReq}),
    .syncOut({debugSync, wakeSync})
  );
  assign wakeS = wakeSync[0];
  assign rtcWakeS = wakeSync[1];
  assign debugS = debugSync;

  // single-cycle APB: every access completes in its access phase
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !penable && !pwrite;
  assign stopTake = stopInstr && (mode_reg == stop_mode_pkg::RUN);
  assign stopEntry = stopTake && ctrl_reg[stop_mode_pkg::CTRL_STOP_INSTR_EN];

  // mode decision at stop entry
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      stop_mode_pkg::RUN: begin
        if (stopTake && ctrl_reg[stop_mode_pkg::CTRL_STOP_INSTR_EN]) begin
          if (debugS) begin
            mode_next = stop_mode_pkg::STOP3;
          end else if (ctrl_reg[stop_mode_pkg::CTRL_LV_DETECT_EN] &&
                       ctrl_reg[stop_mode_pkg::CTRL_LV_STOP_EN]) begin
            mode_next = stop_mode_pkg::STOP3;
          end else if (ctrl_reg[stop_mode_pkg::CTRL_DEEP_STOP_SEL]) begin
            mode_next = stop_mode_pkg::STOP2;
          end else begin
            mode_next = stop_mode_pkg::STOP3;
          end
        end
      end
      stop_mode_pkg::STOP3: begin
        if (wakeS || rtcWakeS) begin
          mode_next = stop_mode_pkg::RUN;
        end
      end
      stop_mode_pkg::STOP2: begin
        if (wakeS || (rtcWakeS && cfgRtc_reg)) begin
          mode_next = stop_mode_pkg::RUN;
        end
      end
      default: mode_next = stop_mode_pkg::RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= stop_mode_pkg::RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // configuration captured at the stop instruction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgDebug_reg <= 1'b0;
      cfgVdetOn_reg <= 1'b0;
      cfgVdetStop_reg <= 1'b0;
      cfgIref_reg <= 1'b0;
      cfgIrefStop_reg <= 1'b0;
      cfgOscHigh_reg <= 1'b0;
      cfgAdcAsync_reg <= 1'b0;
      cfgCmpBg_reg <= 1'b0;
      cfgRtc_reg <= 1'b0;
    end else if (stopEntry) begin
      cfgDebug_reg <= debugS;
      cfgVdetOn_reg <= ctrl_reg[stop_mode_pkg::CTRL_LV_DETECT_EN];
      cfgVdetStop_reg <= ctrl_reg[stop_mode_pkg::CTRL_LV_STOP_EN];
      cfgIref_reg <= ctrl_reg[stop_mode_pkg::CTRL_IREF_EN];
      cfgIrefStop_reg <= ctrl_reg[stop_mode_pkg::CTRL_IREF_STOP_EN];
      cfgOscHigh_reg <= ctrl_reg[stop_mode_pkg::CTRL_OSC_HIGH_RANGE];
      cfgAdcAsync_reg <= ctrl_reg[stop_mode_pkg::CTRL_ADC_ASYNC_CLK];
      cfgCmpBg_reg <= ctrl_reg[stop_mode_pkg::CTRL_CMP_BANDGAP];
      cfgRtc_reg <= ctrl_reg[stop_mode_pkg::CTRL_RTC_STOP_EN];
    end
  end

  // at the entry edge the plan must see the settings being captured, not the last ones
  assign cfgBus.debugOn = stopEntry ? debugS : cfgDebug_reg;
  assign cfgBus.vdetOn = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_LV_DETECT_EN] :
                         cfgVdetOn_reg;
  assign cfgBus.vdetStop = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_LV_STOP_EN] :
                           cfgVdetStop_reg;
  assign cfgBus.irefEn = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_IREF_EN] :
                         cfgIref_reg;
  assign cfgBus.irefStopEn = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_IREF_STOP_EN] :
                             cfgIrefStop_reg;
  assign cfgBus.oscHigh = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_OSC_HIGH_RANGE] :
                          cfgOscHigh_reg;
  assign cfgBus.adcAsync = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_ADC_ASYNC_CLK] :
                           cfgAdcAsync_reg;
  assign cfgBus.cmpBandgap = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_CMP_BANDGAP] :
                             cfgCmpBg_reg;
  assign cfgBus.rtcEn = stopEntry ? ctrl_reg[stop_mode_pkg::CTRL_RTC_STOP_EN] :
                        cfgRtc_reg;
  assign cfgBus.mode = mode_next;

  domain_plan uPlan (
    .cfg(cfgBus),
    .domState(planState)
  );

  // clock gates and domain states, registered from mode_next so they change on the same edge as mode_reg
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periphClkEn <= 1'b1;
      cpuClkEn <= 1'b1;
      debugClkEn <= 1'b1;
      domainState <= '0;
    end else begin
      periphClkEn <= (mode_next == stop_mode_pkg::RUN);
      cpuClkEn <= (mode_next == stop_mode_pkg::RUN);
      debugClkEn <= (mode_next == stop_mode_pkg::RUN) ||
                    ((mode_next == stop_mode_pkg::STOP3) && cfgBus.debugOn);
      domainState <= planState;
    end
  end

  // illegal-opcode reset request, one-cycle pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      illegalOpReset <= 1'b0;
    end else begin
      illegalOpReset <= stopTake && !ctrl_reg[stop_mode_pkg::CTRL_STOP_INSTR_EN];
    end
  end

  // wake flag and pin latch after stop2 exit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerdown_wake_flag_reg <= 1'b0;
      pinLatchHold <= 1'b0;
    end else begin
      if (mode_reg == stop_mode_pkg::STOP2 && mode_next == stop_mode_pkg::RUN) begin
        powerdown_wake_flag_reg <= 1'b1;
      end else if (apbWrite && paddr == stop_mode_pkg::CTRL_ADDR &&
                   pwdata[stop_mode_pkg::CTRL_PD_ACK]) begin
        powerdown_wake_flag_reg <= 1'b0;
      end
      if (mode_next != stop_mode_pkg::RUN) begin
        pinLatchHold <= 1'b1;
      end else if (mode_reg == stop_mode_pkg::STOP3) begin
        pinLatchHold <= 1'b0;
      end else if (apbWrite && paddr == stop_mode_pkg::CTRL_ADDR &&
                   pwdata[stop_mode_pkg::CTRL_PD_ACK] && !(mode_reg == stop_mode_pkg::STOP2)) begin
        pinLatchHold <= 1'b0;
      end
    end
  end

  // control register; acknowledge bit self-clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= stop_mode_pkg::CTRL_RESET;
    end else if (apbWrite && paddr == stop_mode_pkg::CTRL_ADDR) begin
      ctrl_reg <= pwdata[stop_mode_pkg::CTRL_W-1:0] &
                  ~(stop_mode_pkg::CTRL_W'(1) << stop_mode_pkg::CTRL_PD_ACK);
    end
  end

  // event status, write-one-to-clear, set wins
  assign evSet[stop_mode_pkg::EV_STOP3] = (mode_reg != stop_mode_pkg::STOP3) &&
                                          (mode_next == stop_mode_pkg::STOP3);
  assign evSet[stop_mode_pkg::EV_STOP2] = (mode_reg != stop_mode_pkg::STOP2) &&
                                          (mode_next == stop_mode_pkg::STOP2);
  assign evSet[stop_mode_pkg::EV_WAKE] = (mode_reg != stop_mode_pkg::RUN) &&
                                         (mode_next == stop_mode_pkg::RUN);
  assign evSet[stop_mode_pkg::EV_ILLEGAL] = stopTake &&
                                            !ctrl_reg[stop_mode_pkg::CTRL_STOP_INSTR_EN];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evStat_reg <= '0;
    end else begin
      for (int i = 0; i < stop_mode_pkg::EV_W; i++) begin
        if (evSet[i]) begin
          evStat_reg[i] <= 1'b1;
        end else if (apbWrite && paddr == stop_mode_pkg::IRQ_STAT_ADDR && pwdata[i]) begin
          evStat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evMask_reg <= '0;
    end else if (apbWrite && paddr == stop_mode_pkg::IRQ_MASK_ADDR) begin
      evMask_reg <= pwdata[stop_mode_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStat_reg & evMask_reg);
    end
  end

  // APB read data registered in setup phase, ready in access phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == stop_mode_pkg::CTRL_ADDR ||
                 paddr == stop_mode_pkg::STAT_ADDR || paddr == stop_mode_pkg::IRQ_STAT_ADDR ||
                 paddr == stop_mode_pkg::IRQ_MASK_ADDR || paddr == stop_mode_pkg::DOMAIN_ADDR);
      prdata <= '0;
      if (apbRead) begin
        unique case (paddr)
          stop_mode_pkg::CTRL_ADDR: prdata <= 32'(ctrl_reg);
          stop_mode_pkg::STAT_ADDR: prdata <= 32'({pinLatchHold, powerdown_wake_flag_reg,
                                                   debugS, mode_reg});
          stop_mode_pkg::IRQ_STAT_ADDR: prdata <= 32'(evStat_reg);
          stop_mode_pkg::IRQ_MASK_ADDR: prdata <= 32'(evMask_reg);
          stop_mode_pkg::DOMAIN_ADDR: prdata <= 32'(domainState);
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule

/* stop_mode_domain_control_assertions.sv */
// port-level checker for the stop-mode controller
`timescale 1ns/1ps
module stop_mode_domain_control_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stopInstr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic periphClkEn,
  input wire logic cpuClkEn,
  input wire logic debugClkEn,
  input wire logic illegalOpReset,
  input wire logic pinLatchHold,
  input wire logic [2*stop_mode_pkg::DOM_TOTAL-1:0] domainState
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [1:0] cpuD;
  logic [1:0] ramD;
  logic [1:0] regD;
  assign cpuD = domainState[2*stop_mode_pkg::D_CPU+:2];
  assign ramD = domainState[2*stop_mode_pkg::D_RAM+:2];
  assign regD = domainState[2*stop_mode_pkg::D_REG+:2];
  property p_gate_cause; $fell(periphClkEn) |-> $past(stopInstr); endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gating without stop");
  property p_cpu_gated; !periphClkEn |-> !cpuClkEn; endproperty
  a_cpu_gated: assert property (p_cpu_gated) else $error("cpu clock runs in stop");
  property p_debug_reg; !periphClkEn && debugClkEn |-> regD == stop_mode_pkg::DOM_ON; endproperty
  a_debug_reg: assert property (p_debug_reg) else $error("regulator not on");
  property p_no_debug_stop2;
    cpuD == stop_mode_pkg::DOM_OFF |-> !debugClkEn && regD == stop_mode_pkg::DOM_STANDBY;
  endproperty
  a_no_debug_stop2: assert property (p_no_debug_stop2) else $error("debug in deep stop");
  property p_illegal; illegalOpReset |-> periphClkEn ##1 !illegalOpReset; endproperty
  a_illegal: assert property (p_illegal) else $error("illegal reset pulse wrong");
  property p_stop2_pins; cpuD == stop_mode_pkg::DOM_OFF |-> pinLatchHold; endproperty
  a_stop2_pins: assert property (p_stop2_pins) else $error("pins not held");
  property p_ram_standby; !periphClkEn |-> ramD == stop_mode_pkg::DOM_STANDBY; endproperty
  a_ram_standby: assert property (p_ram_standby) else $error("ram not standby");
  property p_run_on; periphClkEn |-> cpuD == stop_mode_pkg::DOM_ON; endproperty
  a_run_on: assert property (p_run_on) else $error("cpu not on in run");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
endmodule
bind stop_mode_domain_control stop_mode_domain_control_assertions chk (.clk(clk), .rstn(rstn),
  .stopInstr(stopInstr), .pready(pready), .pslverr(pslverr), .periphClkEn(periphClkEn),
  .cpuClkEn(cpuClkEn), .debugClkEn(debugClkEn), .illegalOpReset(illegalOpReset),
  .pinLatchHold(pinLatchHold), .domainState(domainState));

/* stop_mode_domain_control_tb.sv */
// self-checking testbench for the stop-mode controller
`timescale 1ns/1ps
module stop_mode_domain_control_tb;
  localparam logic [1:0] ON = stop_mode_pkg::DOM_ON;
  localparam logic [1:0] SB = stop_mode_pkg::DOM_STANDBY;
  localparam logic [1:0] OFF = stop_mode_pkg::DOM_OFF;
  localparam int CPU = stop_mode_pkg::D_CPU, RAM = stop_mode_pkg::D_RAM,
    FLS = stop_mode_pkg::D_FLASH, PRT = stop_mode_pkg::D_PORTS, ADC = stop_mode_pkg::D_ADC,
    CMP = stop_mode_pkg::D_CMP, CLK = stop_mode_pkg::D_CLKGEN, SER = stop_mode_pkg::D_SERIAL,
    TMR = stop_mode_pkg::D_TIMERS, XOS = stop_mode_pkg::D_CRYSTAL, REG = stop_mode_pkg::D_REG,
    RTC = stop_mode_pkg::D_RTC;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic stopInstr = 0, dbgEn = 0, wakeReq = 0, rtcWakeReq = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, periphClkEn, debugClkEn, cpuClkEn, illegalOpReset, pinLatchHold, irq, er;
  logic [27:0] domainState;
  logic [27:0] ds0;
  int fails = 0;
  int nTests = 0;
  int ill;
  always #12.5 clk = ~clk;
  stop_mode_domain_control DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stopInstr(stopInstr), .debug_entry_enable(dbgEn), .wakeReq(wakeReq),
    .rtcWakeReq(rtcWakeReq), .periphClkEn(periphClkEn), .debugClkEn(debugClkEn),
    .cpuClkEn(cpuClkEn), .illegalOpReset(illegalOpReset), .pinLatchHold(pinLatchHold),
    .domainState(domainState), .irq(irq));
  task summarize;
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      $display("ERROR pready expected 1 seen timeout");
      fails++;
      summarize;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task cds(input int q[], input logic [1:0] e);
    foreach (q[k]) chk($sformatf("domain%0d", q[k]), {30'h0, e}, {30'h0, domainState[2*q[k]+:2]});
  endtask
  task doStop;
    @(posedge clk);
    stopInstr <= 1;
    @(posedge clk);
    stopInstr <= 0;
    ill = 0;
    #1;
    ds0 = domainState;
    if (illegalOpReset === 1'b1) ill++;
    repeat (2) begin
      @(posedge clk);
      #1;
      if (illegalOpReset === 1'b1) ill++;
    end
    @(posedge clk);
    #1;
    chk("entryState", {4'h0, ds0}, {4'h0, domainState});
  endtask
  task doWake(input bit rtc);
    int i;
    @(posedge clk);
    if (rtc) rtcWakeReq <= 1;
    else wakeReq <= 1;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      if (periphClkEn === 1'b1) break;
    end
    @(posedge clk);
    wakeReq <= 0;
    rtcWakeReq <= 0;
    repeat (4) @(posedge clk);
    if (i == 12) begin
      $display("ERROR wake expected clocks seen timeout");
      fails++;
      summarize;
    end
    #1;
    cds('{CPU}, ON);
  endtask
  task tReset;
    rdc("ctrl", stop_mode_pkg::CTRL_ADDR, 32'h0000_0001);
    rdc("unmapped", 12'h014, 32'h0);
    chk("slverr", 1, {31'h0, er});
    chk("periphClk", 1, {31'h0, periphClkEn});
    chk("cpuClk", 1, {31'h0, cpuClkEn});
    chk("debugClk", 1, {31'h0, debugClkEn});
  endtask
  task tIllegal;
    apb(1, stop_mode_pkg::IRQ_MASK_ADDR, 32'h0);
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0);
    doStop;
    chk("illegalPulses", 1, ill);
    chk("periphClk", 1, {31'h0, periphClkEn});
    chk("irqMasked", 0, {31'h0, irq});
    rdc("irqStat", stop_mode_pkg::IRQ_STAT_ADDR, 32'h1 << stop_mode_pkg::EV_ILLEGAL);
    apb(1, stop_mode_pkg::IRQ_MASK_ADDR, 32'h1 << stop_mode_pkg::EV_ILLEGAL);
    settle;
    chk("irqSet", 1, {31'h0, irq});
    apb(1, stop_mode_pkg::IRQ_STAT_ADDR, 32'h1 << stop_mode_pkg::EV_ILLEGAL);
    settle;
    chk("irqClr", 0, {31'h0, irq});
  endtask
  task tStop3;
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0000_00D1);
    doStop;
    chk("periphClk", 0, {31'h0, periphClkEn});
    chk("cpuClk", 0, {31'h0, cpuClkEn});
    chk("debugClk", 0, {31'h0, debugClkEn});
    cds('{CPU, RAM, FLS, PRT, SER, TMR, REG}, SB);
    cds('{ADC}, SB);
    cds('{CLK}, SB);
    chk("xoscOn", 0, {31'h0, domainState[2*XOS+:2] === ON});
    doWake(1);
    rdc("irqStat", stop_mode_pkg::IRQ_STAT_ADDR, 32'h5);
    apb(1, stop_mode_pkg::IRQ_STAT_ADDR, 32'hF);
  endtask
  task tStop2;
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0000_0203);
    doStop;
    cds('{CPU, FLS, PRT, ADC, CMP, CLK, SER, TMR, XOS}, OFF);
    cds('{RAM, REG}, SB);
    cds('{RTC}, ON);
    chk("pinHold", 1, {31'h0, pinLatchHold});
    doWake(0);
    chk("pinHoldWake", 1, {31'h0, pinLatchHold});
    rdc("statWake", stop_mode_pkg::STAT_ADDR, 32'h18);
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0000_0401);
    settle;
    chk("pinHoldAck", 0, {31'h0, pinLatchHold});
    rdc("statAck", stop_mode_pkg::STAT_ADDR, 32'h0);
    apb(1, stop_mode_pkg::IRQ_STAT_ADDR, 32'hF);
  endtask
  task tVdet;
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0000_01FF);
    doStop;
    cds('{CPU}, SB);
    cds('{REG}, ON);
    cds('{ADC}, ON);
    cds('{CMP}, ON);
    cds('{CLK}, ON);
    cds('{XOS}, ON);
    doWake(0);
    rdc("ctrlKept", stop_mode_pkg::CTRL_ADDR, 32'h0000_01FF);
  endtask
  task tDebug;
    @(posedge clk);
    dbgEn <= 1;
    settle;
    apb(1, stop_mode_pkg::CTRL_ADDR, 32'h0000_0003);
    doStop;
    cds('{CPU}, SB);
    chk("debugClk", 1, {31'h0, debugClkEn});
    chk("periphClk", 0, {31'h0, periphClkEn});
    cds('{REG}, ON);
    doWake(0);
    chk("debugClkRun", 1, {31'h0, debugClkEn});
    @(posedge clk);
    dbgEn <= 0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    tReset;
    tIllegal;
    tStop3;
    tStop2;
    tVdet;
    tDebug;
    summarize;
  end
endmodule
